// *** rtl/pomc_mode_ctrl.sv ***
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
// Function
// - exactly one of stop, start-up, run, hold
// - stop: no program, retained data kept
// - stop: inhibit outputs, run off, stop on; run keeps blinking until the 3s start-up blink ends
// - start-up block once, unsupervised
// - start-up: inhibit, stop off, blink 3s
// - start-up block done enters run
// - run: cyclic block, timers, image refresh
// - run: outputs enabled, run blinks until the 3s start-up blink ends then on, stop off
// - three breakpoints, hit enters hold, stepping
// - hold: blink run, stop on, inhibit
// - hold freezes timers, real-time clock runs
// - no single step above two breakpoints
// - 100ms watchdog forces defined stop
// - cycle limit at least 1ms, overrun stops
// - run to stop asserts output inhibit
// - inhibited analog: safe or substitute values
// - start: clear inputs, start-up, then cycle
// - cycle order: read, execute, write
// - overall reset erases, keeps network address
// - load sampled 100ms, last/avg/min/max
// - overall reset only in stop, stop flashes
module pomc_mode_ctrl #(
  parameter int MS_CYCLES = pomc_pkg::MS_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire pomc_pkg::pomc_avs_req_t avs_req,
  output pomc_pkg::pomc_avs_rsp_t avs_rsp,
  input wire logic phase_done,
  input wire logic [15:0] exec_addr,
  input wire logic exec_addr_valid,
  input wire logic cpu_busy,
  input wire logic mem_erase_done,
  output pomc_pkg::pomc_seq_t seq,
  output pomc_pkg::pomc_ind_t ind,
  output logic exec_step,
  output logic timer_enable,
  output logic mem_erase_req
);

  pomc_pkg::pomc_state_t s_reg;
  pomc_pkg::pomc_state_t s_next;

  function automatic logic [31:0] pomc_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] pomc_bp_count(input pomc_pkg::pomc_bp_t [2:0] bp);
    logic [1:0] c;
    c = 2'h0;
    for (int i = 0; i < pomc_pkg::NUM_BP; i++) begin
      c = c + {1'b0, bp[i].en};
    end
    return c;
  endfunction

  logic req;
  logic first;
  logic taken;
  logic wr;
  logic [31:0] cmd;
  logic [31:0] wv;
  logic [31:0] rd;
  logic wd_exp;
  logic cyc_exp;
  logic bp_hit;
  logic [6:0] sample;
  logic [10:0] sum;
  logic [9:0][6:0] h;

  always_comb begin
    s_next = s_reg;
    req = avs_req.read | avs_req.write;
    // one wait state: request seen, answer at the next edge
    first = req & s_reg.rsp.waitrequest;
    taken = req & ~s_reg.rsp.waitrequest;
    wr = taken & avs_req.write;
    wv = 32'h0;
    cmd = 32'h0;
    rd = 32'h0;
    wd_exp = 1'b0;
    cyc_exp = 1'b0;
    bp_hit = 1'b0;
    sample = 7'h0;
    sum = 11'h0;
    h = s_reg.hist;
    s_next.rsp.waitrequest = ~first;
    s_next.exec_step = 1'b0;

    case (avs_req.address)
      pomc_pkg::OFS_STATUS: begin
        rd[pomc_pkg::ST_MODE_LSB +: 4] = s_reg.mode;
        rd[pomc_pkg::ST_PHASE_LSB +: 7] = s_reg.phase;
        rd[pomc_pkg::ST_WD_FAULT] = s_reg.wd_fault;
        rd[pomc_pkg::ST_CYC_FAULT] = s_reg.cyc_fault;
        rd[pomc_pkg::ST_ERASE] = s_reg.mem_erase_req;
        rd[pomc_pkg::ST_BPCNT_LSB +: 2] = pomc_bp_count(s_reg.bp);
      end
      pomc_pkg::OFS_CYC_LIMIT: rd[15:0] = s_reg.cyc_limit;
      pomc_pkg::OFS_CONFIG: rd[pomc_pkg::CFG_SUBST] = s_reg.subst;
      pomc_pkg::OFS_BP0: rd = {s_reg.bp[0].en, 15'h0, s_reg.bp[0].addr};
      pomc_pkg::OFS_BP1: rd = {s_reg.bp[1].en, 15'h0, s_reg.bp[1].addr};
      pomc_pkg::OFS_BP2: rd = {s_reg.bp[2].en, 15'h0, s_reg.bp[2].addr};
      pomc_pkg::OFS_LOAD: begin
        rd[pomc_pkg::LD_LAST_LSB +: 7] = s_reg.ld_last;
        rd[pomc_pkg::LD_AVG_LSB +: 7] = s_reg.ld_avg;
        rd[pomc_pkg::LD_MIN_LSB +: 7] = s_reg.ld_min;
        rd[pomc_pkg::LD_MAX_LSB +: 7] = s_reg.ld_max;
      end
      pomc_pkg::OFS_RTC: rd = s_reg.rtc;
      pomc_pkg::OFS_NETADDR: rd = s_reg.netaddr;
      pomc_pkg::OFS_CYC_TIME: rd[15:0] = s_reg.last_cyc;
      default: rd = 32'h0;
    endcase
    if (first & avs_req.read) begin
      s_next.rsp.readdata = rd;
    end

    if (wr) begin
      wv = pomc_merge(32'h0, avs_req.writedata, avs_req.byteenable);
      case (avs_req.address)
        pomc_pkg::OFS_CTRL: cmd = wv;
        pomc_pkg::OFS_CYC_LIMIT: begin
          wv = pomc_merge({16'h0, s_reg.cyc_limit}, avs_req.writedata, avs_req.byteenable);
          // a limit below one millisecond is raised to one millisecond
          s_next.cyc_limit = (wv[15:0] < pomc_pkg::CYC_LIMIT_MIN) ? pomc_pkg::CYC_LIMIT_MIN : wv[15:0];
        end
        pomc_pkg::OFS_CONFIG: begin
          if (avs_req.byteenable[0]) begin
            s_next.subst = avs_req.writedata[pomc_pkg::CFG_SUBST];
          end
        end
        pomc_pkg::OFS_BP0, pomc_pkg::OFS_BP1, pomc_pkg::OFS_BP2: begin
          for (int i = 0; i < pomc_pkg::NUM_BP; i++) begin
            if (avs_req.address == pomc_pkg::OFS_BP0 + 8'(i * 4)) begin
              wv = pomc_merge({s_reg.bp[i].en, 15'h0, s_reg.bp[i].addr}, avs_req.writedata,
                              avs_req.byteenable);
              s_next.bp[i].en = wv[pomc_pkg::BP_EN];
              s_next.bp[i].addr = wv[15:0];
            end
          end
        end
        pomc_pkg::OFS_NETADDR: begin
          s_next.netaddr = pomc_merge(s_reg.netaddr, avs_req.writedata, avs_req.byteenable);
        end
        default: ;
      endcase
    end

    // millisecond time base; the real-time clock never stops
    s_next.ms_tick = (s_reg.ms_div == 32'(MS_CYCLES - 1));
    s_next.ms_div = s_next.ms_tick ? 32'h0 : s_reg.ms_div + 32'h1;
    if (s_reg.ms_tick) begin
      s_next.rtc = s_reg.rtc + 32'h1;
      if (s_reg.blink_ms == 8'(pomc_pkg::BLINK_HALF_MS - 1)) begin
        s_next.blink_ms = 8'h0;
        s_next.blink_lvl = ~s_reg.blink_lvl;
      end else begin
        s_next.blink_ms = s_reg.blink_ms + 8'h1;
      end
      if (s_reg.bl3_ms != 12'h0) begin
        s_next.bl3_ms = s_reg.bl3_ms - 12'h1;
      end
    end

    case (s_reg.mode)
      pomc_pkg::M_STOP: begin
        // program not executed; images, timers and flags left as they were
        s_next.phase = pomc_pkg::PH_IDLE;
        if (s_reg.mem_erase_req & mem_erase_done) begin
          s_next.mem_erase_req = 1'b0;
        end
        if (cmd[pomc_pkg::CTRL_ERASE]) begin
          s_next.mem_erase_req = 1'b1;
        end else if (cmd[pomc_pkg::CTRL_START] & ~s_reg.mem_erase_req & ~cmd[pomc_pkg::CTRL_STOP]) begin
          s_next.mode = pomc_pkg::M_STARTUP;
          s_next.phase = pomc_pkg::PH_CLR_IN;
          s_next.bl3_ms = 12'(pomc_pkg::STARTUP_BLINK_MS);
        end
      end
      pomc_pkg::M_STARTUP: begin
        // no watchdog or cycle monitor runs here
        if (phase_done) begin
          if (s_reg.phase == pomc_pkg::PH_CLR_IN) begin
            s_next.phase = pomc_pkg::PH_STARTUP;
          end else begin
            s_next.mode = pomc_pkg::M_RUN;
            s_next.phase = pomc_pkg::PH_CLR_OUT;
            s_next.wd_ms = 8'h0;
            s_next.cyc_ms = 16'h0;
          end
        end
      end
      pomc_pkg::M_RUN: begin
        if (s_reg.ms_tick) begin
          s_next.wd_ms = s_reg.wd_ms + 8'h1;
          s_next.cyc_ms = s_reg.cyc_ms + 16'h1;
        end
        wd_exp = (s_reg.wd_ms >= 8'(pomc_pkg::WD_TIMEOUT_MS));
        cyc_exp = (s_reg.cyc_ms > s_reg.cyc_limit);
        for (int i = 0; i < pomc_pkg::NUM_BP; i++) begin
          if (s_reg.bp[i].en & (s_reg.bp[i].addr == exec_addr)) begin
            bp_hit = exec_addr_valid & (s_reg.phase == pomc_pkg::PH_EXEC);
          end
        end
        if (bp_hit) begin
          s_next.mode = pomc_pkg::M_HOLD;
        end else if (phase_done) begin
          case (s_reg.phase)
            pomc_pkg::PH_CLR_OUT: begin
              s_next.phase = pomc_pkg::PH_READ_IN;
              s_next.cyc_ms = 16'h0;
            end
            pomc_pkg::PH_READ_IN: s_next.phase = pomc_pkg::PH_EXEC;
            pomc_pkg::PH_EXEC: s_next.phase = pomc_pkg::PH_WRITE_OUT;
            pomc_pkg::PH_WRITE_OUT: begin
              // a completed cycle also retriggers the watchdog
              s_next.phase = pomc_pkg::PH_READ_IN;
              s_next.last_cyc = s_reg.cyc_ms;
              s_next.cyc_ms = 16'h0;
              s_next.wd_ms = 8'h0;
            end
            default: s_next.phase = pomc_pkg::PH_READ_IN;
          endcase
        end
        if (cmd[pomc_pkg::CTRL_KICK]) begin
          s_next.wd_ms = 8'h0;
        end
      end
      pomc_pkg::M_HOLD: begin
        // supervision counters stay frozen with the program timers
        if (cmd[pomc_pkg::CTRL_RESUME]) begin
          s_next.mode = pomc_pkg::M_RUN;
        end else if (cmd[pomc_pkg::CTRL_STEP] &&
                     pomc_bp_count(s_reg.bp) <= 2'(pomc_pkg::STEP_MAX_BP)) begin
          s_next.exec_step = 1'b1;
        end
      end
      default: begin
        s_next.mode = pomc_pkg::M_STOP;
        s_next.phase = pomc_pkg::PH_IDLE;
      end
    endcase

    if (s_reg.mode != pomc_pkg::M_STOP && (cmd[pomc_pkg::CTRL_STOP] | wd_exp | cyc_exp)) begin
      s_next.mode = pomc_pkg::M_STOP;
      s_next.phase = pomc_pkg::PH_IDLE;
      s_next.wd_ms = 8'h0;
      s_next.cyc_ms = 16'h0;
    end

    // sticky faults, write one to clear; a new event beats the clear
    if (wr && avs_req.address == pomc_pkg::OFS_STATUS && avs_req.byteenable[2]) begin
      s_next.wd_fault = s_reg.wd_fault & ~avs_req.writedata[pomc_pkg::ST_WD_FAULT];
      s_next.cyc_fault = s_reg.cyc_fault & ~avs_req.writedata[pomc_pkg::ST_CYC_FAULT];
    end
    s_next.wd_fault = s_next.wd_fault | wd_exp;
    s_next.cyc_fault = s_next.cyc_fault | cyc_exp;

    // load: one busy sample per millisecond, so a window count is a percentage
    if (s_reg.ms_tick) begin
      sample = s_reg.ld_acc + {6'h0, cpu_busy};
      if (s_reg.ld_sub == 7'(pomc_pkg::LOAD_WIN_MS - 1)) begin
        h[s_reg.hist_idx] = sample;
        for (int i = 0; i < pomc_pkg::LOAD_HIST; i++) begin
          sum = sum + {4'h0, h[i]};
        end
        s_next.hist = h;
        s_next.hist_idx = (s_reg.hist_idx == 4'(pomc_pkg::LOAD_HIST - 1)) ? 4'h0 : s_reg.hist_idx + 4'h1;
        s_next.ld_last = sample;
        s_next.ld_avg = 7'(sum / 11'(pomc_pkg::LOAD_HIST));
        s_next.ld_min = (sample < s_reg.ld_min) ? sample : s_reg.ld_min;
        s_next.ld_max = (sample > s_reg.ld_max) ? sample : s_reg.ld_max;
        s_next.ld_sub = 7'h0;
        s_next.ld_acc = 7'h0;
      end else begin
        s_next.ld_sub = s_reg.ld_sub + 7'h1;
        s_next.ld_acc = sample;
      end
    end

    // outputs follow the next state so they line up with mode and phase
    s_next.seq.in_clear = (s_next.phase == pomc_pkg::PH_CLR_IN);
    s_next.seq.startup_run = (s_next.phase == pomc_pkg::PH_STARTUP);
    s_next.seq.out_clear = (s_next.phase == pomc_pkg::PH_CLR_OUT);
    s_next.seq.in_read = (s_next.mode == pomc_pkg::M_RUN) && (s_next.phase == pomc_pkg::PH_READ_IN);
    s_next.seq.cyclic_run = (s_next.mode == pomc_pkg::M_RUN) && (s_next.phase == pomc_pkg::PH_EXEC);
    s_next.seq.out_write = (s_next.mode == pomc_pkg::M_RUN) && (s_next.phase == pomc_pkg::PH_WRITE_OUT);
    s_next.timer_enable = (s_next.mode == pomc_pkg::M_RUN) || (s_next.mode == pomc_pkg::M_STARTUP);
    s_next.ind.output_inhibit = (s_next.mode != pomc_pkg::M_RUN);
    if (s_next.bl3_ms != 12'h0 || s_next.mode == pomc_pkg::M_STARTUP || s_next.mode == pomc_pkg::M_HOLD) begin
      s_next.ind.run_indicator = s_next.blink_lvl;
    end else begin
      s_next.ind.run_indicator = (s_next.mode == pomc_pkg::M_RUN);
    end
    if (s_next.mode == pomc_pkg::M_STOP) begin
      s_next.ind.stop_indicator = s_next.mem_erase_req ? s_next.blink_lvl : 1'b1;
    end else begin
      s_next.ind.stop_indicator = (s_next.mode == pomc_pkg::M_HOLD);
    end
    // modules pick 0V, 0mA or 4mA by their own range when safe is asserted
    s_next.ind.ao_safe = s_next.ind.output_inhibit & ~s_next.subst;
    s_next.ind.ao_subst = s_next.ind.output_inhibit & s_next.subst;

    if (srst) begin
      // network address is cleared only here, never by an overall reset
      s_next = '0;
      s_next.mode = pomc_pkg::M_STOP;
      s_next.phase = pomc_pkg::PH_IDLE;
      s_next.rsp.waitrequest = 1'b1;
      s_next.ind.output_inhibit = 1'b1;
      s_next.ind.stop_indicator = 1'b1;
      s_next.ind.ao_safe = 1'b1;
      s_next.cyc_limit = pomc_pkg::CYC_LIMIT_RST;
      s_next.ld_min = pomc_pkg::LOAD_MIN_RST;
    end
  end

  always_ff @(posedge mclk) begin
    s_reg <= s_next;
  end

  assign avs_rsp = s_reg.rsp;
  assign seq = s_reg.seq;
  assign ind = s_reg.ind;
  assign exec_step = s_reg.exec_step;
  assign timer_enable = s_reg.timer_enable;
  assign mem_erase_req = s_reg.mem_erase_req;

endmodule

// *** rtl/pomc_pkg.sv ***
package pomc_pkg;
  // timing, in the unit printed, then load history and breakpoint counts
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WD_TIMEOUT_MS = 100;
  localparam int STARTUP_BLINK_MS = 3000;
  localparam int BLINK_HALF_MS = 250;
  localparam int LOAD_WIN_MS = 100;
  localparam int LOAD_HIST = 10;
  localparam int NUM_BP = 3;
  localparam int STEP_MAX_BP = 2;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CYC_LIMIT = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_BP0 = 8'h10;
  localparam logic [7:0] OFS_BP1 = 8'h14;
  localparam logic [7:0] OFS_BP2 = 8'h18;
  localparam logic [7:0] OFS_LOAD = 8'h1c;
  localparam logic [7:0] OFS_RTC = 8'h20;
  localparam logic [7:0] OFS_NETADDR = 8'h24;
  localparam logic [7:0] OFS_CYC_TIME = 8'h28;

  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_RESUME = 2;
  localparam int CTRL_STEP = 3;
  localparam int CTRL_ERASE = 4;
  localparam int CTRL_KICK = 5;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_PHASE_LSB = 4;
  localparam int ST_WD_FAULT = 16;
  localparam int ST_CYC_FAULT = 17;
  localparam int ST_ERASE = 18;
  localparam int ST_BPCNT_LSB = 20;
  localparam int CFG_SUBST = 0;
  localparam int BP_EN = 31;
  localparam int LD_LAST_LSB = 0;
  localparam int LD_AVG_LSB = 8;
  localparam int LD_MIN_LSB = 16;
  localparam int LD_MAX_LSB = 24;

  // reset values and the minimum cycle limit
  localparam logic [15:0] CYC_LIMIT_RST = 16'h0096;
  localparam logic [15:0] CYC_LIMIT_MIN = 16'h0001;
  localparam logic [6:0] LOAD_MIN_RST = 7'h64;

  typedef enum logic [3:0] {
    M_STOP = 4'h1,
    M_STARTUP = 4'h2,
    M_RUN = 4'h4,
    M_HOLD = 4'h8
  } pomc_mode_t;

  typedef enum logic [6:0] {
    PH_IDLE = 7'h01,
    PH_CLR_IN = 7'h02,
    PH_STARTUP = 7'h04,
    PH_CLR_OUT = 7'h08,
    PH_READ_IN = 7'h10,
    PH_EXEC = 7'h20,
    PH_WRITE_OUT = 7'h40
  } pomc_phase_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } pomc_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } pomc_avs_rsp_t;

  typedef struct packed {
    logic in_clear;
    logic startup_run;
    logic out_clear;
    logic in_read;
    logic cyclic_run;
    logic out_write;
  } pomc_seq_t;

  typedef struct packed {
    logic output_inhibit;
    logic run_indicator;
    logic stop_indicator;
    logic ao_safe;
    logic ao_subst;
  } pomc_ind_t;

  typedef struct packed {
    logic en;
    logic [15:0] addr;
  } pomc_bp_t;

  typedef struct packed {
    pomc_mode_t mode;
    pomc_phase_t phase;
    pomc_avs_rsp_t rsp;
    pomc_seq_t seq;
    pomc_ind_t ind;
    logic exec_step;
    logic timer_enable;
    logic mem_erase_req;
    logic [31:0] ms_div;
    logic ms_tick;
    logic [31:0] rtc;
    logic [7:0] wd_ms;
    logic [15:0] cyc_ms;
    logic [15:0] last_cyc;
    logic [15:0] cyc_limit;
    logic subst;
    pomc_bp_t [2:0] bp;
    logic wd_fault;
    logic cyc_fault;
    logic [7:0] blink_ms;
    logic blink_lvl;
    logic [11:0] bl3_ms;
    logic [6:0] ld_sub;
    logic [6:0] ld_acc;
    logic [9:0][6:0] hist;
    logic [3:0] hist_idx;
    logic [6:0] ld_last;
    logic [6:0] ld_avg;
    logic [6:0] ld_min;
    logic [6:0] ld_max;
    logic [31:0] netaddr;
  } pomc_state_t;
endpackage

// *** verification/pomc_io_model.sv ***
`timescale 1ns/1ns
module pomc_io_model (
  input wire logic mclk,
  input wire logic srst,
  input wire pomc_pkg::pomc_seq_t seq,
  input wire logic mem_erase_req,
  input wire logic [7:0] lat,
  input wire logic hang,
  output logic phase_done,
  output logic [15:0] exec_addr,
  output logic exec_addr_valid,
  output logic cpu_busy,
  output logic mem_erase_done
);
  logic [7:0] cnt;
  logic [7:0] ecnt;
  // every phase answers lat+1 cycles after it starts
  // hang stalls the cyclic block so the watchdog runs out
  always @(posedge mclk) begin
    phase_done <= 1'b0;
    mem_erase_done <= 1'b0;
    if (srst || seq == '0 || phase_done) begin
      cnt <= 8'h00;
    end else if (!(hang && seq.cyclic_run)) begin
      cnt <= cnt + 8'h01;
      phase_done <= (cnt == lat);
    end
    ecnt <= mem_erase_req ? ecnt + 8'h01 : 8'h00;
    if (mem_erase_req && ecnt == lat) begin
      mem_erase_done <= 1'b1;
    end
    // address bus toggles when no instruction is presented
    exec_addr <= srst ? 16'h0000 : (seq.cyclic_run ? {8'h00, cnt} : ~exec_addr);
    exec_addr_valid <= seq.cyclic_run;
    cpu_busy <= seq.cyclic_run;
  end
endmodule

// *** verification/pomc_mode_ctrl_sva.sv ***
`timescale 1ns/1ns
module pomc_mode_ctrl_sva #(
  parameter int MS_CYCLES = pomc_pkg::MS_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire pomc_pkg::pomc_avs_req_t avs_req,
  input wire pomc_pkg::pomc_avs_rsp_t avs_rsp,
  input wire logic phase_done,
  input wire logic [15:0] exec_addr,
  input wire logic exec_addr_valid,
  input wire logic cpu_busy,
  input wire logic mem_erase_done,
  input wire pomc_pkg::pomc_seq_t seq,
  input wire pomc_pkg::pomc_ind_t ind,
  input wire logic exec_step,
  input wire logic timer_enable,
  input wire logic mem_erase_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  AST_ONE_PHASE: assert property ($onehot0(seq))
    else $error("two phase outputs active");
  AST_RUN_OUTPUTS: assert property (!ind.output_inhibit |-> !ind.stop_indicator && timer_enable)
    else $error("outputs enabled outside run");
  AST_STARTUP_INHIBIT: assert property (seq.in_clear || seq.startup_run |-> ind.output_inhibit && !ind.stop_indicator)
    else $error("start-up indicators wrong");
  AST_CYCLIC_ENABLED: assert property (seq.cyclic_run |-> !ind.output_inhibit)
    else $error("cyclic block runs while inhibited");
  AST_ANALOG_SAFE: assert property ((ind.ao_safe || ind.ao_subst) == ind.output_inhibit && !(ind.ao_safe && ind.ao_subst))
    else $error("analog safe state wrong");
  AST_FROZEN_IN_STOP: assert property (ind.stop_indicator |-> !timer_enable && !seq.cyclic_run)
    else $error("timers or program running with stop lit");
  AST_STARTUP_ORDER: assert property ($rose(seq.startup_run) |-> $past(seq.in_clear))
    else $error("start-up block before input clear");
  AST_OUTCLR_ORDER: assert property ($rose(seq.out_clear) |-> $past(seq.startup_run))
    else $error("output clear not after start-up block");
  AST_WRITE_ORDER: assert property ($rose(seq.out_write) |-> $past(seq.cyclic_run))
    else $error("output write not after cyclic block");
  AST_READ_ORDER: assert property ($rose(seq.in_read) |-> $past(seq.out_clear) || $past(seq.out_write))
    else $error("input read out of order");
  AST_STEP_IN_HOLD: assert property (exec_step |-> ind.output_inhibit && ind.stop_indicator && !timer_enable)
    else $error("single step outside hold");
  AST_ERASE_STOP: assert property (mem_erase_req |-> ind.output_inhibit && !timer_enable)
    else $error("erase outside stop");
  AST_WAIT_ONE: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest |=>
    !avs_rsp.waitrequest ##1 avs_rsp.waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  COV_STEP: cover property (exec_step);
  COV_CYCLE: cover property (seq.out_write);
  COV_ERASE: cover property (mem_erase_req ##1 !mem_erase_req);
  COV_TO_STOP: cover property ($rose(ind.output_inhibit));
endmodule

bind pomc_mode_ctrl pomc_mode_ctrl_sva #(.MS_CYCLES(MS_CYCLES)) sva_u (.mclk(mclk), .srst(srst),
  .avs_req(avs_req), .avs_rsp(avs_rsp), .phase_done(phase_done), .exec_addr(exec_addr),
  .exec_addr_valid(exec_addr_valid), .cpu_busy(cpu_busy), .mem_erase_done(mem_erase_done), .seq(seq),
  .ind(ind), .exec_step(exec_step), .timer_enable(timer_enable), .mem_erase_req(mem_erase_req));

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  localparam int MSC = 10;
  logic mclk, srst, phase_done, exec_addr_valid, cpu_busy, mem_erase_done, exec_step, timer_enable;
  logic mem_erase_req, hang, seen_low, seen_high;
  logic [15:0] exec_addr, bpa;
  logic [7:0] lat;
  logic [31:0] net;
  pomc_pkg::pomc_avs_req_t avs_req;
  pomc_pkg::pomc_avs_rsp_t avs_rsp;
  pomc_pkg::pomc_seq_t seq;
  pomc_pkg::pomc_ind_t ind;
  int errors, num_checks, cycles, steps, t0, el;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];

  pomc_mode_ctrl #(.MS_CYCLES(MSC)) dut_u (.mclk(mclk), .srst(srst), .avs_req(avs_req), .avs_rsp(avs_rsp),
    .phase_done(phase_done), .exec_addr(exec_addr), .exec_addr_valid(exec_addr_valid), .cpu_busy(cpu_busy),
    .mem_erase_done(mem_erase_done), .seq(seq), .ind(ind), .exec_step(exec_step),
    .timer_enable(timer_enable), .mem_erase_req(mem_erase_req));
  pomc_io_model io_u (.mclk(mclk), .srst(srst), .seq(seq), .mem_erase_req(mem_erase_req), .lat(lat),
    .hang(hang), .phase_done(phase_done), .exec_addr(exec_addr), .exec_addr_valid(exec_addr_valid),
    .cpu_busy(cpu_busy), .mem_erase_done(mem_erase_done));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic complete_run;
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // run indicator is masked: it may still be blinking from start-up
  task automatic chk_ind(input logic [4:0] e);
    cmp({27'h0, e & 5'h17}, {27'h0, ind & 5'h17});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_req.read <= !wr;
    avs_req.write <= wr;
    avs_req.address <= a;
    avs_req.writedata <= d;
    do @(posedge mclk); while (avs_rsp.waitrequest !== 1'b0);
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic cmd(input int b);
    bus(1'b1, pomc_pkg::OFS_CTRL, 32'h1 << b);
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (exec_step === 1'b1) steps <= steps + 1;
    if (avs_req.read === 1'b1 && avs_rsp.waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        cmp(32'h0, 32'hffff_ffff);
      end else begin
        cmp(exp_q.pop_front(), avs_rsp.readdata & msk_q.pop_front());
      end
    end
    if (cycles == 45000) begin
      errors++;
      complete_run;
    end
  end

  initial begin
    void'($urandom(24));
    srst = 1'b1;
    avs_req = '0;
    avs_req.byteenable = 4'hf;
    hang = 1'b0;
    lat = 8'($urandom_range(50, 30));
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    tick(1);
    chk_ind(5'b10110);
    rd(pomc_pkg::OFS_STATUS, 32'h0000_0011, 32'h0007_07ff);
    rd(pomc_pkg::OFS_CYC_LIMIT, {16'h0, pomc_pkg::CYC_LIMIT_RST}, 32'h0000_ffff);
    // no load window has closed yet: minimum still at its 100 percent start
    rd(pomc_pkg::OFS_LOAD, {8'h0, 1'b0, pomc_pkg::LOAD_MIN_RST, 16'h0}, 32'h7f7f_7f7f);
    rd(8'h3c, 32'h0, 32'hffff_ffff);
    net = $urandom();
    bus(1'b1, pomc_pkg::OFS_NETADDR, net);
    cmd(pomc_pkg::CTRL_ERASE);
    rd(pomc_pkg::OFS_STATUS, 32'h0004_0001, 32'h0004_000f);
    // erase flashes the stop lamp, still in the dark first half period here
    chk_ind(5'b10010);
    while (mem_erase_req !== 1'b0) @(posedge mclk);
    rd(pomc_pkg::OFS_NETADDR, net, 32'hffff_ffff);
    rd(pomc_pkg::OFS_STATUS, 32'h0000_0001, 32'h0004_000f);
    chk_ind(5'b10110);
    t0 = cycles;
    cmd(pomc_pkg::CTRL_START);
    tick(1);
    chk_ind(5'b10010);
    rd(pomc_pkg::OFS_STATUS, 32'h0000_0022, 32'h0000_07ff);
    while (ind.output_inhibit !== 1'b0) @(posedge mclk);
    seen_low = 1'b0;
    repeat (2600) begin
      @(posedge mclk);
      if (ind.run_indicator === 1'b0) seen_low = 1'b1;
    end
    cmp(32'h1, {31'h0, seen_low});
    while (cycles - t0 < 300 * MSC * 10 + 100) @(posedge mclk);
    seen_low = 1'b0;
    repeat (300) begin
      @(posedge mclk);
      if (ind.run_indicator !== 1'b1) seen_low = 1'b1;
    end
    cmp(32'h0, {31'h0, seen_low});
    chk_ind(5'b00000);
    rd(pomc_pkg::OFS_STATUS, 32'h0000_0004, 32'h0003_000f);
    bus(1'b1, pomc_pkg::OFS_CONFIG, 32'h1);
    bpa = 16'($urandom_range(15, 3));
    bus(1'b1, pomc_pkg::OFS_BP0, {1'b1, 15'h0, bpa});
    while (ind.stop_indicator !== 1'b1) @(posedge mclk);
    tick(1);
    chk_ind(5'b10101);
    rd(pomc_pkg::OFS_STATUS, 32'h0010_0008, 32'h0033_000f);
    cmd(pomc_pkg::CTRL_STEP);
    tick(3);
    cmp(32'h1, 32'(steps));
    bus(1'b1, pomc_pkg::OFS_BP1, {1'b1, 15'h0, bpa + 16'h1});
    bus(1'b1, pomc_pkg::OFS_BP2, {1'b1, 15'h0, bpa + 16'h2});
    cmd(pomc_pkg::CTRL_STEP);
    tick(3);
    cmp(32'h1, 32'(steps));
    rd(pomc_pkg::OFS_STATUS, 32'h0030_0008, 32'h0030_000f);
    bus(1'b1, pomc_pkg::OFS_BP2, 32'h0);
    cmd(pomc_pkg::CTRL_STEP);
    tick(3);
    cmp(32'h2, 32'(steps));
    bus(1'b1, pomc_pkg::OFS_BP0, 32'h0);
    bus(1'b1, pomc_pkg::OFS_BP1, 32'h0);
    cmd(pomc_pkg::CTRL_RESUME);
    while (ind.output_inhibit !== 1'b0) @(posedge mclk);
    hang <= 1'b1;
    t0 = cycles;
    while (ind.output_inhibit !== 1'b1) @(posedge mclk);
    el = cycles - t0;
    cmp(32'h1, {31'h0, el >= 85 * MSC && el <= 102 * MSC});
    tick(1);
    chk_ind(5'b10101);
    rd(pomc_pkg::OFS_STATUS, 32'h0001_0001, 32'h0003_000f);
    hang <= 1'b0;
    bus(1'b1, pomc_pkg::OFS_CYC_LIMIT, 32'h0);
    rd(pomc_pkg::OFS_CYC_LIMIT, {16'h0, pomc_pkg::CYC_LIMIT_MIN}, 32'h0000_ffff);
    cmd(pomc_pkg::CTRL_START);
    while (seq.startup_run !== 1'b1) @(posedge mclk);
    // start-up outlasts the 1 ms limit on purpose: it must not be supervised
    tick(2 * MSC);
    rd(pomc_pkg::OFS_STATUS, 32'h0000_0042, 32'h0002_07ff);
    while (ind.output_inhibit !== 1'b0) @(posedge mclk);
    while (ind.output_inhibit !== 1'b1) @(posedge mclk);
    rd(pomc_pkg::OFS_STATUS, 32'h0002_0001, 32'h0002_000f);
    // start-up blinking outlives the overrun stop; two idle load windows pass meanwhile
    seen_low = 1'b0;
    seen_high = 1'b0;
    repeat (2600) begin
      @(posedge mclk);
      if (ind.run_indicator === 1'b0) seen_low = 1'b1;
      if (ind.run_indicator === 1'b1) seen_high = 1'b1;
    end
    cmp(32'h3, {30'h0, seen_high, seen_low});
    rd(pomc_pkg::OFS_LOAD, 32'h0, 32'h007f_007f);
    tick(2);
    complete_run;
  end
endmodule
